// *** ebps_pin_sharing.sv ***
`timescale 1ns/10ps
module ebps_pin_sharing (
    input wire logic clk,
    input wire logic resetn,
    input wire logic single_chip,
    input wire ebps_pkg::ebps_width_t bus_width,
    input wire logic [15:0] addr_low_en,
    input wire logic [7:0] addr_mid_en,
    input wire logic addr_top_en,
    input wire logic dma_end_en,
    input wire logic ready_en,
    input wire logic release_en,
    input wire logic read_en,
    input wire logic [15:0] bus_dout,
    input wire logic bus_dout_oe,
    output logic [15:0] bus_din,
    input wire logic [24:0] bus_addr,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic [1:0] byte_en,
    input wire logic dma_end_ch0,
    input wire logic cycle_active,
    output logic cycle_done,
    output logic bus_owned,
    input wire logic [46:0] port_out,
    input wire logic [46:0] port_oe,
    output logic [46:0] port_in,
    input wire logic [7:0] data_hi_lane_in,
    output logic [7:0] data_hi_lane_out,
    output logic [7:0] data_hi_lane_oe,
    input wire logic [7:0] data_top_lane_in,
    output logic [7:0] data_top_lane_out,
    output logic [7:0] data_top_lane_oe,
    input wire logic [15:0] addr_low_in,
    output logic [15:0] addr_low_out,
    output logic [15:0] addr_low_oe,
    input wire logic [7:0] addr_mid_in,
    output logic [7:0] addr_mid_out,
    output logic [7:0] addr_mid_oe,
    input wire logic addr_bit_top_in,
    output logic addr_bit_top_out,
    output logic addr_bit_top_oe,
    input wire logic wait_ready_in,
    output logic wait_ready_out,
    output logic wait_ready_oe,
    input wire logic bus_grant_n_in,
    output logic bus_grant_n_out,
    output logic bus_grant_n_oe,
    input wire logic bus_release_req_in,
    output logic bus_release_req_out,
    output logic bus_release_req_oe,
    input wire logic read_strobe_n_in,
    output logic read_strobe_n_out,
    output logic read_strobe_n_oe,
    input wire logic write_strobe_0_n_in,
    output logic write_strobe_0_n_out,
    output logic write_strobe_0_n_oe,
    input wire logic write_strobe_1_n_in,
    output logic write_strobe_1_n_out,
    output logic write_strobe_1_n_oe
);
    ebps_pkg::ebps_state_t state_q, state_d;
    logic [46:0] sel, bout, boe, pin_in, pin_out, pin_oe, bus_in;
    logic ext, wide, owned, ready_sel, release_sel, ready_ok, release_req;

    assign ext = !single_chip;
    assign wide = (bus_width == ebps_pkg::EBPS_WIDTH16);
    assign owned = (state_q == ebps_pkg::EBPS_OWN);
    assign ready_sel = ext && ready_en;
    assign release_sel = ext && release_en;
    assign ready_ok = !ready_sel || bus_in[ebps_pkg::IDX_READY];
    assign release_req = release_sel && bus_in[ebps_pkg::IDX_RELEASE];

    // function select per pin
    always_comb begin
        sel = '0;
        sel[ebps_pkg::IDX_DATA_HI +: ebps_pkg::LANE_W] = {ebps_pkg::LANE_W{ext && wide}};
        sel[ebps_pkg::IDX_DATA_TOP +: ebps_pkg::LANE_W] = {ebps_pkg::LANE_W{ext}};
        sel[ebps_pkg::IDX_ADDR_LOW +: ebps_pkg::ADDR_LOW_W] = addr_low_en & {16{ext}};
        sel[ebps_pkg::IDX_ADDR_MID +: ebps_pkg::ADDR_MID_W] = addr_mid_en & {8{ext}};
        sel[ebps_pkg::IDX_ADDR_TOP] = dma_end_en || (ext && addr_top_en);
        sel[ebps_pkg::IDX_READY] = ready_sel;
        sel[ebps_pkg::IDX_GRANT] = release_sel;
        sel[ebps_pkg::IDX_RELEASE] = release_sel;
        sel[ebps_pkg::IDX_READ] = ext && read_en;
        sel[ebps_pkg::IDX_WRITE0] = ext;
        sel[ebps_pkg::IDX_WRITE1] = ext && wide;
    end

    // bus-side values; bus outputs other than grant float while another master holds the bus
    always_comb begin
        bout = '0;
        boe = '0;
        bout[ebps_pkg::IDX_DATA_HI +: 16] = bus_dout;
        boe[ebps_pkg::IDX_DATA_HI +: 16] = {16{owned && bus_dout_oe}};
        bout[ebps_pkg::IDX_ADDR_LOW +: 24] = bus_addr[23:0];
        boe[ebps_pkg::IDX_ADDR_LOW +: 24] = {24{owned}};
        // end-of-transfer has priority: it is not a bus signal and never floats
        bout[ebps_pkg::IDX_ADDR_TOP] = dma_end_en ? dma_end_ch0 : bus_addr[24];
        boe[ebps_pkg::IDX_ADDR_TOP] = dma_end_en || owned;
        bout[ebps_pkg::IDX_GRANT] = (state_q != ebps_pkg::EBPS_GRANT);
        boe[ebps_pkg::IDX_GRANT] = 1'h1;
        bout[ebps_pkg::IDX_READ] = rd_strobe_n;
        boe[ebps_pkg::IDX_READ] = owned;
        // 8-bit: strobe 0 covers the only lane; 16-bit: one strobe per lane
        bout[ebps_pkg::IDX_WRITE0] = wr_strobe_n | (wide && !byte_en[1]);
        boe[ebps_pkg::IDX_WRITE0] = owned;
        bout[ebps_pkg::IDX_WRITE1] = wr_strobe_n | !byte_en[0];
        boe[ebps_pkg::IDX_WRITE1] = owned;
    end

    // bus release: a cycle in flight always completes before the bus floats
    always_comb begin
        state_d = state_q;
        case (state_q)
            ebps_pkg::EBPS_OWN: begin
                if (release_req && !cycle_active) begin
                    state_d = ebps_pkg::EBPS_FLOAT;
                end
            end
            ebps_pkg::EBPS_FLOAT: begin
                state_d = ebps_pkg::EBPS_GRANT;
            end
            ebps_pkg::EBPS_GRANT: begin
                if (!release_req) begin
                    state_d = ebps_pkg::EBPS_TAKE;
                end
            end
            ebps_pkg::EBPS_TAKE: begin
                state_d = ebps_pkg::EBPS_OWN;
            end
            default: begin
                state_d = ebps_pkg::EBPS_OWN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ebps_pkg::EBPS_OWN;
        end else begin
            state_q <= state_d;
        end
    end

    assign pin_in = {write_strobe_1_n_in, write_strobe_0_n_in, read_strobe_n_in, bus_release_req_in,
                     bus_grant_n_in, wait_ready_in, addr_bit_top_in, addr_mid_in, addr_low_in,
                     data_top_lane_in, data_hi_lane_in};

    ebps_pin_cell #(.N(ebps_pkg::PIN_COUNT)) u_cell (
        .clk(clk),
        .resetn(resetn),
        .bus_sel(sel),
        .bus_out(bout),
        .bus_oe(boe),
        .port_out(port_out),
        .port_oe(port_oe),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .bus_in(bus_in),
        .port_in(port_in)
    );

    assign {write_strobe_1_n_out, write_strobe_0_n_out, read_strobe_n_out, bus_release_req_out,
            bus_grant_n_out, wait_ready_out, addr_bit_top_out, addr_mid_out, addr_low_out,
            data_top_lane_out, data_hi_lane_out} = pin_out;
    assign {write_strobe_1_n_oe, write_strobe_0_n_oe, read_strobe_n_oe, bus_release_req_oe,
            bus_grant_n_oe, wait_ready_oe, addr_bit_top_oe, addr_mid_oe, addr_low_oe,
            data_top_lane_oe, data_hi_lane_oe} = pin_oe;

    assign bus_din = bus_in[ebps_pkg::IDX_DATA_HI +: 16];
    assign bus_owned = owned;
    // ready is seen two cycles late through the synchroniser, so waits stretch by that much
    assign cycle_done = cycle_active && owned && ready_ok;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_hi_lane_port;
        (single_chip || !wide) |=> (data_hi_lane_oe == $past(port_oe[7:0]));
    endproperty
    a_hi_lane_port: assert property (p_hi_lane_port) else $error("hi lane not on port");

    property p_top_lane_bus;
        (ext && owned && bus_dout_oe) |=> (data_top_lane_oe == 8'hFF) && (data_top_lane_out == $past(bus_dout[15:8]));
    endproperty
    a_top_lane_bus: assert property (p_top_lane_bus) else $error("top lane not driving data");

    property p_addr_low;
        (ext && owned) |=> addr_low_out == (($past(bus_addr[15:0]) & $past(addr_low_en))
                                           | ($past(port_out[31:16]) & ~$past(addr_low_en)));
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("low address pin mix wrong");

    property p_addr_mid;
        (ext && owned && addr_mid_en == 8'hFF) |=> (addr_mid_oe == 8'hFF) && (addr_mid_out == $past(bus_addr[23:16]));
    endproperty
    a_addr_mid: assert property (p_addr_mid) else $error("mid address not driven");

    property p_end_ch0;
        dma_end_en |=> addr_bit_top_oe && (addr_bit_top_out == $past(dma_end_ch0));
    endproperty
    a_end_ch0: assert property (p_end_ch0) else $error("end-of-transfer not on top pin");

    property p_ready_hold;
        (ready_sel && cycle_active && !bus_in[ebps_pkg::IDX_READY]) |-> !cycle_done;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("cycle finished while ready low");

    property p_grant_low;
        (release_sel && owned && release_req && !cycle_active) |-> ##3 !bus_grant_n_out && bus_grant_n_oe;
    endproperty
    a_grant_low: assert property (p_grant_low) else $error("grant not low after release");

    property p_read_strobe;
        (ext && read_en && owned) |=> read_strobe_n_oe && (read_strobe_n_out == $past(rd_strobe_n));
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe not on pin");

    property p_write8;
        (ext && !wide && owned) |=> (write_strobe_0_n_out == $past(wr_strobe_n)) && write_strobe_0_n_oe;
    endproperty
    a_write8: assert property (p_write8) else $error("8-bit write strobe wrong");

    property p_wr1_reset;
        $rose(resetn) |-> !write_strobe_1_n_oe;
    endproperty
    a_wr1_reset: assert property (p_wr1_reset) else $error("write strobe 1 driven in reset");

    property p_port_blocked;
        ext |-> (port_in[15:8] == 8'h00);
    endproperty
    a_port_blocked: assert property (p_port_blocked) else $error("port sampled a bus pin");

    c_grant: cover property (state_q == ebps_pkg::EBPS_GRANT ##1 state_q == ebps_pkg::EBPS_TAKE);
    c_wait: cover property (cycle_active && !cycle_done ##1 cycle_done);
    c_end_ch0: cover property (dma_end_en && dma_end_ch0);

endmodule

// *** ebps_pkg.sv ***
package ebps_pkg;

    // pin vector layout, lowest index first
    localparam int PIN_COUNT = 47;
    localparam int IDX_DATA_HI = 0;
    localparam int IDX_DATA_TOP = 8;
    localparam int IDX_ADDR_LOW = 16;
    localparam int IDX_ADDR_MID = 32;
    localparam int IDX_ADDR_TOP = 40;
    localparam int IDX_READY = 41;
    localparam int IDX_GRANT = 42;
    localparam int IDX_RELEASE = 43;
    localparam int IDX_READ = 44;
    localparam int IDX_WRITE0 = 45;
    localparam int IDX_WRITE1 = 46;

    localparam int LANE_W = 8;
    localparam int ADDR_LOW_W = 16;
    localparam int ADDR_MID_W = 8;
    localparam int ADDR_W = 25;

    // reset value of every pin output register and enable
    localparam logic PIN_RESET = 1'h0;

    typedef enum logic [0:0] {
        EBPS_WIDTH8 = 1'h0,
        EBPS_WIDTH16 = 1'h1
    } ebps_width_t;

    // gray order along own -> float -> grant -> take -> own
    typedef enum logic [1:0] {
        EBPS_OWN = 2'h0,
        EBPS_FLOAT = 2'h1,
        EBPS_GRANT = 2'h3,
        EBPS_TAKE = 2'h2
    } ebps_state_t;

endpackage

// *** ebps_pin_cell.sv ***
`timescale 1ns/10ps
module ebps_pin_cell #(
    parameter int N = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [N-1:0] bus_sel,
    input wire logic [N-1:0] bus_out,
    input wire logic [N-1:0] bus_oe,
    input wire logic [N-1:0] port_out,
    input wire logic [N-1:0] port_oe,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] pin_out,
    output logic [N-1:0] pin_oe,
    output logic [N-1:0] bus_in,
    output logic [N-1:0] port_in
);
    logic [N-1:0] out_q, out_d;
    logic [N-1:0] oe_q, oe_d;
    logic [N-1:0] meta_q, meta_d;
    logic [N-1:0] sync_q, sync_d;

    // the deselected function neither drives nor samples the pin
    always_comb begin
        out_d = (bus_sel & bus_out) | (~bus_sel & port_out);
        oe_d = (bus_sel & bus_oe) | (~bus_sel & port_oe);
        meta_d = pin_in;
        sync_d = meta_q;
    end

    // enables reset to zero, so every pin floats while reset is held
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_q <= {N{ebps_pkg::PIN_RESET}};
            oe_q <= {N{ebps_pkg::PIN_RESET}};
            meta_q <= {N{ebps_pkg::PIN_RESET}};
            sync_q <= {N{ebps_pkg::PIN_RESET}};
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign bus_in = sync_q & bus_sel;
    assign port_in = sync_q & ~bus_sel;

endmodule

// *** ebps_far_side.sv ***
`timescale 1ns/10ps
module ebps_far_side #(
    parameter logic [15:0] READ_DATA = 16'hC35A
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] wait_states,
    input wire logic want_bus,
    input wire logic read_strobe_n,
    output logic wait_ready,
    output logic release_req,
    output logic [15:0] lane
);
    logic [3:0] cnt_q;
    logic [15:0] pat_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 4'h0;
            pat_q <= 16'h0;
        end else begin
            // lanes nobody reads drift every cycle so stale data cannot pass
            pat_q <= pat_q + 16'h3F1;
            if (read_strobe_n) begin
                cnt_q <= 4'h0;
            end else if (cnt_q != wait_states) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // ready stays low until the slave's wait count is served
    assign wait_ready = !read_strobe_n && (cnt_q == wait_states);
    assign release_req = want_bus;
    assign lane = read_strobe_n ? pat_q : READ_DATA;
endmodule

// *** test_external_bus_pin_sharing.sv ***
`timescale 1ns/10ps
module test_external_bus_pin_sharing;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic single_chip = 1'h0;
    ebps_pkg::ebps_width_t bus_width = ebps_pkg::EBPS_WIDTH16;
    logic [15:0] addr_low_en = 16'hFFFF;
    logic [7:0] addr_mid_en = 8'hFF;
    logic addr_top_en = 1'h1, dma_end_en = 1'h0, ready_en = 1'h1, release_en = 1'h1, read_en = 1'h1;
    logic [15:0] bus_dout = 16'hA55A;
    logic [24:0] bus_addr = 25'h1ABCDEF;
    logic bus_dout_oe = 1'h0, rd_strobe_n = 1'h1, wr_strobe_n = 1'h1, dma_end_ch0 = 1'h0, cycle_active = 1'h0;
    logic [1:0] byte_en = 2'h0;
    logic [46:0] port_out = 47'h2A5A3C3C96C3;
    // ready, release and read pins stay port inputs, so no stale port level reaches the bus logic
    logic [46:0] port_oe = 47'h65FFFFFFFFFF;
    logic [3:0] wait_states = 4'h4;
    logic want_bus = 1'h0;
    logic [15:0] bus_din, addr_low_in, addr_low_out, addr_low_oe, lane_far;
    logic [46:0] port_in;
    logic [7:0] data_hi_lane_in, data_hi_lane_out, data_hi_lane_oe, data_top_lane_in, data_top_lane_out;
    logic [7:0] data_top_lane_oe, addr_mid_in, addr_mid_out, addr_mid_oe;
    logic cycle_done, bus_owned, addr_bit_top_in, addr_bit_top_out, addr_bit_top_oe, wait_ready_in;
    logic wait_ready_out, wait_ready_oe, bus_grant_n_in, bus_grant_n_out, bus_grant_n_oe, bus_release_req_in;
    logic bus_release_req_out, bus_release_req_oe, read_strobe_n_in, read_strobe_n_out, read_strobe_n_oe;
    logic write_strobe_0_n_in, write_strobe_0_n_out, write_strobe_0_n_oe, write_strobe_1_n_in;
    logic write_strobe_1_n_out, write_strobe_1_n_oe, wait_ready_far, req_far;
    int errors = 0;
    int compares = 0;
    int n;

    always #20 clk = ~clk;

    // lines nobody drives show the inverse of their last value, except write strobe 1, which reads high
    assign addr_low_in = ~(addr_low_out ^ addr_low_oe);
    assign addr_mid_in = ~(addr_mid_out ^ addr_mid_oe);
    assign addr_bit_top_in = ~(addr_bit_top_out ^ addr_bit_top_oe);
    assign bus_grant_n_in = ~(bus_grant_n_out ^ bus_grant_n_oe);
    assign read_strobe_n_in = ~(read_strobe_n_out ^ read_strobe_n_oe);
    assign write_strobe_0_n_in = ~(write_strobe_0_n_out ^ write_strobe_0_n_oe);
    assign write_strobe_1_n_in = write_strobe_1_n_out | ~write_strobe_1_n_oe;
    assign data_hi_lane_in = (data_hi_lane_oe & data_hi_lane_out) | (~data_hi_lane_oe & lane_far[7:0]);
    assign data_top_lane_in = (data_top_lane_oe & data_top_lane_out) | (~data_top_lane_oe & lane_far[15:8]);
    assign wait_ready_in = (wait_ready_oe & wait_ready_out) | (~wait_ready_oe & wait_ready_far);
    assign bus_release_req_in = (bus_release_req_oe & bus_release_req_out) | (~bus_release_req_oe & req_far);

    ebps_far_side u_far (.clk, .resetn, .wait_states, .want_bus, .read_strobe_n(read_strobe_n_in),
        .wait_ready(wait_ready_far), .release_req(req_far), .lane(lane_far));

    ebps_pin_sharing u_dut (.clk, .resetn, .single_chip, .bus_width, .addr_low_en, .addr_mid_en, .addr_top_en,
        .dma_end_en, .ready_en, .release_en, .read_en, .bus_dout, .bus_dout_oe, .bus_din, .bus_addr, .rd_strobe_n,
        .wr_strobe_n, .byte_en, .dma_end_ch0, .cycle_active, .cycle_done, .bus_owned, .port_out, .port_oe, .port_in,
        .data_hi_lane_in, .data_hi_lane_out, .data_hi_lane_oe, .data_top_lane_in, .data_top_lane_out,
        .data_top_lane_oe, .addr_low_in, .addr_low_out, .addr_low_oe, .addr_mid_in, .addr_mid_out, .addr_mid_oe,
        .addr_bit_top_in, .addr_bit_top_out, .addr_bit_top_oe, .wait_ready_in, .wait_ready_out, .wait_ready_oe,
        .bus_grant_n_in, .bus_grant_n_out, .bus_grant_n_oe, .bus_release_req_in, .bus_release_req_out,
        .bus_release_req_oe, .read_strobe_n_in, .read_strobe_n_out, .read_strobe_n_oe, .write_strobe_0_n_in,
        .write_strobe_0_n_out, .write_strobe_0_n_oe, .write_strobe_1_n_in, .write_strobe_1_n_out,
        .write_strobe_1_n_oe);

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        step(19);
        cmp({data_hi_lane_oe, data_top_lane_oe, addr_low_oe, addr_mid_oe, addr_bit_top_oe, wait_ready_oe,
            bus_grant_n_oe, bus_release_req_oe, read_strobe_n_oe, write_strobe_0_n_oe, write_strobe_1_n_oe}, 0);
        cmp(write_strobe_1_n_in, 1'h1);
        step(1);
        resetn = 1'h1;
        step(1);
        cmp({addr_bit_top_out, addr_mid_out, addr_low_out}, bus_addr);
        cmp({addr_bit_top_oe, addr_mid_oe, addr_low_oe}, 25'h1FFFFFF);
        addr_low_en = 16'h00FF;
        addr_top_en = 1'h0;
        addr_mid_en = 8'h0F;
        ready_en = 1'h0;
        release_en = 1'h0;
        read_en = 1'h0;
        step(1);
        cmp({addr_mid_out, addr_low_out}, {port_out[39:36], bus_addr[19:16], port_out[31:24], bus_addr[7:0]});
        cmp({addr_bit_top_out, wait_ready_out, bus_grant_n_out, read_strobe_n_out},
            {port_out[40], port_out[41], port_out[42], port_out[44]});
        step(2);
        cmp(port_in[31:16], {port_out[31:24], 8'h00});
        ready_en = 1'h1;
        release_en = 1'h1;
        read_en = 1'h1;
        addr_low_en = 16'hFFFF;
        addr_top_en = 1'h1;
        bus_width = ebps_pkg::EBPS_WIDTH8;
        bus_dout_oe = 1'h1;
        step(1);
        cmp({data_top_lane_out, data_hi_lane_out, data_top_lane_oe}, {bus_dout[15:8], port_out[7:0], 8'hFF});
        single_chip = 1'h1;
        step(1);
        cmp({data_top_lane_out, data_hi_lane_out}, port_out[15:0]);
        single_chip = 1'h0;
        bus_width = ebps_pkg::EBPS_WIDTH16;
        wr_strobe_n = 1'h0;
        step(1);
        cmp({data_top_lane_out, data_hi_lane_out}, bus_dout);
        for (int b = 0; b < 4; b++) begin
            byte_en = b[1:0];
            step(1);
            cmp({write_strobe_0_n_out, write_strobe_1_n_out}, {~b[1], ~b[0]});
        end
        bus_width = ebps_pkg::EBPS_WIDTH8;
        step(1);
        cmp({write_strobe_0_n_out, write_strobe_1_n_out}, {1'h0, port_out[46]});
        wr_strobe_n = 1'h1;
        bus_dout_oe = 1'h0;
        dma_end_en = 1'h1;
        dma_end_ch0 = 1'h1;
        single_chip = 1'h1;
        step(1);
        cmp({addr_bit_top_oe, addr_bit_top_out}, 2'h3);
        dma_end_ch0 = 1'h0;
        step(1);
        cmp(addr_bit_top_out, 1'h0);
        dma_end_en = 1'h0;
        single_chip = 1'h0;
        bus_width = ebps_pkg::EBPS_WIDTH16;
        cycle_active = 1'h1;
        rd_strobe_n = 1'h0;
        for (n = 1; n < 30; n++) begin
            step(1);
            if (cycle_done === 1'h1)
                break;
        end
        cmp(n, 7);
        cmp({read_strobe_n_out, bus_din}, {1'h0, 16'hC35A});
        rd_strobe_n = 1'h1;
        want_bus = 1'h1;
        step(6);
        cmp(bus_owned, 1'h1);
        cycle_active = 1'h0;
        for (n = 1; n < 12; n++) begin
            step(1);
            if (bus_grant_n_out === 1'h0)
                break;
        end
        cmp(n, 3);
        cmp({bus_owned, addr_low_oe, read_strobe_n_oe, bus_grant_n_oe}, {18'h0, 1'h1});
        want_bus = 1'h0;
        for (n = 1; n < 12; n++) begin
            step(1);
            if (bus_owned === 1'h1)
                break;
        end
        cmp({n < 12, bus_grant_n_out}, 2'h3);
        end_of_test;
    end

    initial begin
        #200000;
        errors++;
        end_of_test;
    end
endmodule
